// file: design/fsec_erase_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module fsec_erase_ctrl #(
  parameter int unsigned SSE_CYC_P = fsec_pkg::SSE_CYC,
  parameter int unsigned SE_CYC_P = fsec_pkg::SE_CYC,
  parameter int unsigned DSE_CYC_P = fsec_pkg::DSE_CYC,
  parameter int unsigned PROG_CYC_P = fsec_pkg::PROG_CYC
) (
  // System
  input wire logic clk,
  input wire logic rst,
  // Serial link
  input wire logic sclk,
  input wire logic csN,
  input wire logic [3:0] serialDataLine,
  // Configuration
  input wire fsec_pkg::fsec_mode_type protoMode,
  input wire logic addr4Byte,
  input wire logic [fsec_pkg::SECTORS-1:0] sectorLock,
  // Array and program path
  input wire logic progStart,
  input wire logic arrayTimeout,
  // Status
  output var fsec_pkg::fsec_flags_type flagStatus,
  output var logic welOut,
  output var logic busyOut,
  output var fsec_pkg::fsec_commit_type eraseCommit,
  output var logic progDone
);
  import fsec_pkg::*;

  typedef enum logic [1:0] {ST_IDLE, ST_ERASE, ST_PROG, ST_SUSPENDING} fsec_state_type;

  // Link domain
  logic firstR;
  logic frameTogR;
  logic [5:0] clkCntR;
  logic [3:0][MAX_CLOCKS-1:0] laneShR;

  // Clock domain crossing
  logic csS1;
  logic csS2;
  logic csS3;
  logic togS1;
  logic togS2;
  logic seenTogR;

  // Decode
  logic [2:0] laneW;
  logic [7:0] streamBits;
  logic [7:0] cmdLen;
  logic [MAX_CLOCKS-1:0] stream;
  logic [7:0] opcode;
  logic [31:0] addr;
  logic shortOk;
  logic longOk;
  logic frameEnd;

  // Engine
  fsec_state_type st;
  logic [31:0] remR;
  logic [31:0] progRemR;
  logic [31:0] latR;
  fsec_kind_type kindR;
  logic [31:0] baseR;
  logic eraseHeldR;
  logic progHeldR;
  logic suspProgR;
  fsec_flags_type flagR;
  logic welR;

  // Events
  logic idleCmd;
  logic isErase;
  fsec_kind_type newKind;
  logic [31:0] newBase;
  logic [31:0] newCyc;
  logic protHit;
  logic eraseCmd;
  logic eraseStart;
  logic eraseRefuse;
  logic eraseFin;
  logic progFin;
  logic suspErase;
  logic suspProg;
  logic suspEraseLate;
  logic suspProgLate;
  logic latDone;
  logic resumeProg;
  logic resumeErase;
  logic progGo;
  logic doWren;
  logic doWrdi;
  logic doClr;

  // Frame start marker, set while deselected
  always_ff @(posedge sclk or posedge csN)
  begin
    if (csN)
    begin
      firstR <= 1'b1;
    end
    else
    begin
      firstR <= 1'b0;
    end
  end

  always_ff @(posedge sclk or posedge rst)
  begin
    if (rst)
    begin
      frameTogR <= 1'b0;
    end
    else if (!csN && firstR)
    begin
      frameTogR <= ~frameTogR;
    end
  end

  // Every lane is captured on the rising edge; width decided later
  always_ff @(posedge sclk)
  begin
    if (!csN)
    begin
      if (firstR)
      begin
        clkCntR <= 6'h01;
      end
      else if (clkCntR != CNT_MAX)
      begin
        clkCntR <= clkCntR + 6'h01;
      end
      for (int i = 0; i < 4; i++)
      begin
        laneShR[i] <= {laneShR[i][MAX_CLOCKS-2:0], serialDataLine[i]};
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      csS1 <= 1'b1;
      csS2 <= 1'b1;
      csS3 <= 1'b1;
      togS1 <= 1'b0;
      togS2 <= 1'b0;
      seenTogR <= 1'b0;
    end
    else
    begin
      csS1 <= csN;
      csS2 <= csS1;
      csS3 <= csS2;
      togS1 <= frameTogR;
      togS2 <= togS1;
      if (frameEnd)
      begin
        seenTogR <= togS2;
      end
    end
  end

  // Rebuild the bit stream, most significant line first in each clock
  function automatic logic [MAX_CLOCKS-1:0] joinBits(
    input logic [3:0][MAX_CLOCKS-1:0] ln,
    input logic [2:0] w
  );
    logic [MAX_CLOCKS-1:0] res;
    res = '0;
    for (int k = MAX_CLOCKS - 1; k >= 0; k--)
    begin
      for (int b = 3; b >= 0; b--)
      begin
        if (b < int'(w))
        begin
          res = {res[MAX_CLOCKS-2:0], ln[b][k]};
        end
      end
    end
    return res;
  endfunction : joinBits

  always_comb
  begin
    unique case (protoMode)
      MODE_DUAL: laneW = 3'd2;
      MODE_QUAD: laneW = 3'd4;
      default: laneW = 3'd1;
    endcase
  end

  // Clock count to last address bit: 8+A, 4+A/2, 2+A/4
  assign streamBits = 8'(clkCntR) * 8'(laneW);
  assign cmdLen = 8'(OPC_BITS) + (addr4Byte ? 8'(ADDR4_BITS) : 8'(ADDR3_BITS));
  assign stream = joinBits(laneShR, laneW);
  assign shortOk = (streamBits == 8'(OPC_BITS));
  assign longOk = (streamBits == cmdLen);
  assign opcode = shortOk ? stream[7:0] : (addr4Byte ? stream[39:32] : stream[31:24]);
  assign addr = addr4Byte ? stream[31:0] : {8'h00, stream[23:0]};
  // Frame end: synchronized rise of csN after a new frame toggle, whatever the length
  assign frameEnd = csS2 && !csS3 && (togS2 != seenTogR);

  assign idleCmd = frameEnd && (st == ST_IDLE);
  assign isErase = longOk && (opcode == OP_SUB_ERASE || opcode == OP_SEC_ERASE
                              || opcode == OP_DIE_ERASE);

  always_comb
  begin
    newKind = KIND_SUB;
    newBase = {addr[31:SUB_LSB], 12'h000};
    newCyc = SSE_CYC_P - 32'd1;
    protHit = sectorLock[addr[DIE_LSB:SEC_LSB]];
    if (opcode == OP_SEC_ERASE)
    begin
      newKind = KIND_SEC;
      newBase = {addr[31:SEC_LSB], 16'h0000};
      newCyc = SE_CYC_P - 32'd1;
    end
    else if (opcode == OP_DIE_ERASE)
    begin
      newKind = KIND_DIE;
      newBase = {addr[31:DIE_LSB], 25'h0000000};
      newCyc = DSE_CYC_P - 32'd1;
      protHit = |sectorLock;
    end
  end

  // No erase while anything is held in suspend
  assign eraseCmd = idleCmd && isErase && welR && !eraseHeldR && !progHeldR;
  assign eraseStart = eraseCmd && !protHit;
  assign eraseRefuse = eraseCmd && protHit;
  assign eraseFin = (st == ST_ERASE) && (remR == 32'd0);
  assign progFin = (st == ST_PROG) && (progRemR == 32'd0);
  // Die erase cannot be suspended; idle suspend does nothing
  assign suspErase = frameEnd && shortOk && opcode == OP_SUSPEND && st == ST_ERASE
                     && kindR != KIND_DIE && !eraseFin;
  assign suspProg = frameEnd && shortOk && opcode == OP_SUSPEND && st == ST_PROG
                    && !progFin;
  assign suspEraseLate = suspErase && (remR >= ELAT_CYC);
  assign suspProgLate = suspProg && (progRemR >= PLAT_CYC);
  assign latDone = (st == ST_SUSPENDING) && (latR == 32'd0);
  // Program held last is resumed first
  assign resumeProg = idleCmd && shortOk && opcode == OP_RESUME && progHeldR;
  assign resumeErase = idleCmd && shortOk && opcode == OP_RESUME && !progHeldR
                       && eraseHeldR;
  assign progGo = progStart && (st == ST_IDLE) && !progHeldR && !eraseStart
                  && !resumeErase && !resumeProg;
  assign doWren = idleCmd && shortOk && opcode == OP_WREN;
  assign doWrdi = idleCmd && shortOk && opcode == OP_WRDI;
  assign doClr = idleCmd && shortOk && opcode == OP_CLR_FLAGS;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      st <= ST_IDLE;
      remR <= '0;
      progRemR <= '0;
      latR <= '0;
      kindR <= KIND_SUB;
      baseR <= '0;
      eraseHeldR <= 1'b0;
      progHeldR <= 1'b0;
      suspProgR <= 1'b0;
    end
    else
    begin
      unique case (st)
        ST_IDLE:
        begin
          if (eraseStart)
          begin
            st <= ST_ERASE;
            remR <= newCyc;
            kindR <= newKind;
            baseR <= newBase;
          end
          else if (resumeProg)
          begin
            st <= ST_PROG;
            progHeldR <= 1'b0;
          end
          else if (resumeErase)
          begin
            st <= ST_ERASE;
            eraseHeldR <= 1'b0;
          end
          else if (progGo)
          begin
            st <= ST_PROG;
            progRemR <= PROG_CYC_P - 32'd1;
          end
        end
        ST_ERASE:
        begin
          if (eraseFin)
          begin
            st <= ST_IDLE;
          end
          else if (suspEraseLate)
          begin
            st <= ST_SUSPENDING;
            latR <= ELAT_CYC - 32'd1;
            suspProgR <= 1'b0;
          end
          else
          begin
            remR <= remR - 32'd1;
          end
        end
        ST_PROG:
        begin
          if (progFin)
          begin
            st <= ST_IDLE;
          end
          else if (suspProgLate)
          begin
            st <= ST_SUSPENDING;
            latR <= PLAT_CYC - 32'd1;
            suspProgR <= 1'b1;
          end
          else
          begin
            progRemR <= progRemR - 32'd1;
          end
        end
        ST_SUSPENDING:
        begin
          if (latR == 32'd0)
          begin
            st <= ST_IDLE;
            if (suspProgR)
            begin
              progHeldR <= 1'b1;
            end
            else
            begin
              eraseHeldR <= 1'b1;
            end
          end
          else
          begin
            latR <= latR - 32'd1;
          end
        end
      endcase
    end
  end

  // Flag status; later assignments win, so sets override a clear
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      flagR <= FLAGS_RST;
    end
    else
    begin
      if (doClr)
      begin
        flagR.eraseErr <= 1'b0;
        flagR.progErr <= 1'b0;
        flagR.protErr <= 1'b0;
      end
      if (eraseStart || resumeProg || resumeErase || progGo)
      begin
        flagR.ready <= 1'b0;
      end
      if (resumeProg)
      begin
        flagR.progSusp <= 1'b0;
      end
      if (resumeErase)
      begin
        flagR.eraseSusp <= 1'b0;
      end
      if (eraseFin)
      begin
        flagR.ready <= 1'b1;
        flagR.eraseSusp <= 1'b0;
        if (arrayTimeout)
        begin
          flagR.eraseErr <= 1'b1;
        end
      end
      if (progFin)
      begin
        flagR.ready <= 1'b1;
        flagR.progSusp <= 1'b0;
      end
      if (suspErase)
      begin
        flagR.eraseSusp <= 1'b1;
      end
      if (suspProg)
      begin
        flagR.progSusp <= 1'b1;
      end
      if (latDone)
      begin
        flagR.ready <= 1'b1;
      end
      if (eraseRefuse)
      begin
        flagR.protErr <= 1'b1;
        flagR.eraseErr <= 1'b1;
      end
    end
  end

  // Write enable latch; kept through refusals and a protection error
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      welR <= 1'b0;
    end
    else if (eraseFin)
    begin
      welR <= 1'b0;
    end
    else if (doWren)
    begin
      welR <= 1'b1;
    end
    else if (doWrdi && !flagR.protErr)
    begin
      welR <= 1'b0;
    end
  end

  // Region commit to the array: fill with all ones
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      eraseCommit <= '0;
      progDone <= 1'b0;
    end
    else
    begin
      eraseCommit.go <= eraseFin && !arrayTimeout;
      eraseCommit.kind <= kindR;
      eraseCommit.base <= baseR;
      progDone <= progFin;
    end
  end

  assign flagStatus = flagR;
  assign welOut = welR;
  assign busyOut = (st != ST_IDLE);

endmodule : fsec_erase_ctrl
`default_nettype wire

// file: design/fsec_pkg.sv
package fsec_pkg;

  localparam int unsigned CLK_MHZ = 100;

  localparam logic [7:0] OP_WREN = 8'h06;
  localparam logic [7:0] OP_WRDI = 8'h04;
  localparam logic [7:0] OP_SUB_ERASE = 8'h20;
  localparam logic [7:0] OP_SEC_ERASE = 8'hd8;
  localparam logic [7:0] OP_DIE_ERASE = 8'hc4;
  localparam logic [7:0] OP_SUSPEND = 8'h75;
  localparam logic [7:0] OP_RESUME = 8'h7a;
  localparam logic [7:0] OP_CLR_FLAGS = 8'h50;

  localparam int unsigned SUBSECTOR_ERASE_TIME_US = 400;
  localparam int unsigned SECTOR_ERASE_TIME_US = 1000;
  localparam int unsigned DIE_ERASE_TIME_US = 20000;
  localparam int unsigned PROGRAM_TIME_US = 500;
  localparam int unsigned PROG_SUSP_LAT_US = 7;
  localparam int unsigned ERASE_SUSP_LAT_US = 15;

  localparam int unsigned SSE_CYC = SUBSECTOR_ERASE_TIME_US * CLK_MHZ;
  localparam int unsigned SE_CYC = SECTOR_ERASE_TIME_US * CLK_MHZ;
  localparam int unsigned DSE_CYC = DIE_ERASE_TIME_US * CLK_MHZ;
  localparam int unsigned PROG_CYC = PROGRAM_TIME_US * CLK_MHZ;
  localparam logic [31:0] PLAT_CYC = 32'(PROG_SUSP_LAT_US * CLK_MHZ);
  localparam logic [31:0] ELAT_CYC = 32'(ERASE_SUSP_LAT_US * CLK_MHZ);

  localparam int unsigned SUB_LSB = 12;
  localparam int unsigned SEC_LSB = 16;
  localparam int unsigned DIE_LSB = 25;
  localparam int unsigned SECTORS = 1024;
  localparam int unsigned OPC_BITS = 8;
  localparam int unsigned ADDR3_BITS = 24;
  localparam int unsigned ADDR4_BITS = 32;
  localparam int unsigned MAX_CLOCKS = 40;
  localparam logic [5:0] CNT_MAX = 6'h3f;

  typedef enum logic [1:0] {MODE_EXT, MODE_DUAL, MODE_QUAD} fsec_mode_type;
  typedef enum logic [1:0] {KIND_SUB, KIND_SEC, KIND_DIE} fsec_kind_type;

  typedef struct packed {
    logic ready;
    logic eraseSusp;
    logic eraseErr;
    logic progErr;
    logic rsvd3;
    logic progSusp;
    logic protErr;
    logic rsvd0;
  } fsec_flags_type;

  localparam fsec_flags_type FLAGS_RST = 8'h80;

  typedef struct packed {
    logic go;
    fsec_kind_type kind;
    logic [31:0] base;
  } fsec_commit_type;

endpackage : fsec_pkg

// file: dv/fsec_erase_ctrl_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module fsec_erase_ctrl_assertions #(
  parameter int unsigned SSE_CYC_P = fsec_pkg::SSE_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Watched outputs
  input wire fsec_pkg::fsec_flags_type flagStatus,
  input wire logic welOut,
  input wire logic busyOut,
  input wire fsec_pkg::fsec_commit_type eraseCommit,
  input wire logic progDone
);
  import fsec_pkg::*;
  logic [31:0] runCnt_r;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  // Length of the current busy stretch
  always_ff @(posedge clk)
  begin
    if (rst || !busyOut)
      runCnt_r <= 32'h0;
    else
      runCnt_r <= runCnt_r + 32'h1;
  end
  a_reset_flags: assert property (disable iff (1'b0)
    rst |=> flagStatus == FLAGS_RST && !welOut && !busyOut) else $error("reset state wrong");
  a_ready_busy: assert property (flagStatus.ready != busyOut)
    else $error("ready and busy disagree");
  a_commit_after: assert property (eraseCommit.go |->
    !busyOut && $past(busyOut)) else $error("commit without finish");
  a_commit_wel: assert property (eraseCommit.go |-> !welOut && flagStatus.ready)
    else $error("latch set at commit");
  a_commit_pulse: assert property (eraseCommit.go |=> !eraseCommit.go)
    else $error("commit longer than a cycle");
  a_sub_align: assert property (eraseCommit.go && eraseCommit.kind == KIND_SUB |->
    eraseCommit.base[11:0] == 12'h000) else $error("subsector base unaligned");
  a_sec_align: assert property (eraseCommit.go && eraseCommit.kind == KIND_SEC |->
    eraseCommit.base[15:0] == 16'h0000) else $error("sector base unaligned");
  a_die_align: assert property (eraseCommit.go && eraseCommit.kind == KIND_DIE |->
    eraseCommit.base[24:0] == 25'h0) else $error("die base unaligned");
  a_sub_time: assert property (eraseCommit.go && eraseCommit.kind == KIND_SUB |->
    $past(runCnt_r, 2) <= SSE_CYC_P + 1) else $error("subsector erase too long");
  a_prot_refuse: assert property ($rose(flagStatus.protErr) |->
    welOut && flagStatus.eraseErr && !busyOut) else $error("protected erase mishandled");
  a_timeout_clear: assert property ($rose(flagStatus.eraseErr) && !flagStatus.protErr |->
    !welOut && !eraseCommit.go) else $error("timeout mishandled");
  a_esusp_busy: assert property ($rose(flagStatus.eraseSusp) |->
    busyOut && !flagStatus.ready) else $error("erase suspend while not busy");
  a_psusp_busy: assert property ($rose(flagStatus.progSusp) |->
    busyOut && !flagStatus.ready) else $error("program suspend while not busy");
  cover property (eraseCommit.go && eraseCommit.kind == KIND_DIE);
  cover property ($rose(flagStatus.eraseSusp));
  cover property ($rose(flagStatus.protErr));
  cover property (progDone);
endmodule : fsec_erase_ctrl_assertions
bind fsec_erase_ctrl fsec_erase_ctrl_assertions #(
  .SSE_CYC_P(SSE_CYC_P)
) u_chk (
  .clk(clk),
  .rst(rst),
  .flagStatus(flagStatus),
  .welOut(welOut),
  .busyOut(busyOut),
  .eraseCommit(eraseCommit),
  .progDone(progDone)
);
`default_nettype wire

// file: dv/fsec_spi_host.sv
`timescale 1ns/1ps
`default_nettype none
module fsec_spi_host (
  // Link
  output var logic sclk,
  output var logic csN,
  output var logic [3:0] serialDataLine
);
  initial
  begin
    sclk = 1'b0;
    csN = 1'b1;
    serialDataLine = 4'h0;
  end
  // Frame of nb stream bits, w lines per clock, first bit first
  task automatic send(input logic [39:0] s, input int nb, input int w);
    logic [43:0] t;
    int i;
    t = {s, 4'h0};
    #7;
    csN = 1'b0;
    for (i = 0; i < nb; i += w)
    begin
      serialDataLine = t[43 - i -: 4] >> (4 - w);
      #15 sclk = 1'b1;
      #15 sclk = 1'b0;
    end
    #8 csN = 1'b1;
    // Released lines must not keep the last value
    serialDataLine = ~serialDataLine;
    #50;
  endtask : send
endmodule : fsec_spi_host
`default_nettype wire

// file: dv/fsec_erase_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none
module fsec_erase_ctrl_tb;
  import fsec_pkg::*;
  localparam int SSE = 3000;
  localparam int SE = 4000;
  localparam int DSE = 5000;
  localparam logic [7:0] OPS [3] = '{OP_SUB_ERASE, OP_SEC_ERASE, OP_DIE_ERASE};
  localparam logic [31:0] ADS [3] = '{32'h00123456, 32'h0234abcd, 32'h03001234};
  localparam logic [31:0] BASES [3] = '{32'h00123000, 32'h02340000, 32'h02000000};
  localparam int NA [3] = '{24, 32, 32};
  localparam int WD [3] = '{1, 2, 4};
  localparam int DUR [3] = '{SSE, SE, DSE};
  logic clk = 1'b0;
  logic rst = 1'b0;
  wire logic sclk;
  wire logic csN;
  wire logic [3:0] serialDataLine;
  fsec_mode_type protoMode = MODE_EXT;
  logic addr4Byte = 1'b0;
  logic [SECTORS-1:0] sectorLock = '0;
  logic progStart = 1'b0;
  logic arrayTimeout = 1'b0;
  fsec_flags_type flagStatus;
  logic welOut;
  logic busyOut;
  fsec_commit_type eraseCommit;
  logic progDone;
  int num_errors = 0;
  int compares = 0;
  int cyc = 0;
  int t0;
  int k;
  always #5 clk = ~clk;
  fsec_erase_ctrl #(.SSE_CYC_P(SSE), .SE_CYC_P(SE), .DSE_CYC_P(DSE), .PROG_CYC_P(3000)) u_dut (
    .clk(clk), .rst(rst), .sclk(sclk), .csN(csN), .serialDataLine(serialDataLine),
    .protoMode(protoMode), .addr4Byte(addr4Byte), .sectorLock(sectorLock),
    .progStart(progStart), .arrayTimeout(arrayTimeout), .flagStatus(flagStatus),
    .welOut(welOut), .busyOut(busyOut), .eraseCommit(eraseCommit), .progDone(progDone));
  fsec_spi_host u_host (.sclk(sclk), .csN(csN), .serialDataLine(serialDataLine));
  task automatic give_verdict();
    $display("compares %0d errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    compares++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic frame(input logic [7:0] op, input logic [31:0] ad, input int na, input int w,
    input int extra);
    u_host.send({op, ad << (32 - na)}, 8 + na + extra, w);
    repeat (6) @(posedge clk);
    #1;
  endtask : frame
  // Wait for commit (0), program done (1) or ready (2)
  task automatic wt(input int sel, input int lim);
    int n;
    for (n = 0; n < lim; n++)
    begin
      @(posedge clk);
      #1;
      if ((sel == 0 && eraseCommit.go === 1'b1) || (sel == 1 && progDone === 1'b1)
        || (sel == 2 && flagStatus.ready === 1'b1))
        break;
    end
    chk(n < lim, 1'b1);
  endtask : wt
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 50000)
    begin
      num_errors++;
      give_verdict();
    end
  end
  initial
  begin
    // A real rising edge, so the link toggle is cleared too
    rst <= 1'b1;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    chk({flagStatus, welOut, busyOut}, {FLAGS_RST, 2'b00});
    frame(OP_SUB_ERASE, 32'h1000, 24, 1, 0);
    chk({flagStatus, welOut, busyOut}, {8'h80, 2'b00});
    frame(OP_WREN, 0, 0, 1, 0);
    chk(welOut, 1'b1);
    frame(OP_WRDI, 0, 0, 1, 0);
    chk(welOut, 1'b0);
    frame(OP_WREN, 0, 0, 1, 0);
    frame(OP_SUB_ERASE, 32'h1000, 24, 1, 1);
    chk({flagStatus, welOut, busyOut}, {8'h80, 2'b10});
    for (k = 0; k < 3; k++)
    begin
      @(posedge clk);
      protoMode <= fsec_mode_type'(k);
      addr4Byte <= (k != 0);
      frame(OP_WREN, 0, 0, WD[k], 0);
      frame(OPS[k], ADS[k], NA[k], WD[k], 0);
      t0 = cyc;
      chk({flagStatus.ready, busyOut}, 2'b01);
      wt(0, DUR[k] + 100);
      // Erase starts about 8 cycles before the frame task returns
      chk((cyc - t0) inside {[DUR[k] - 9 : DUR[k] - 7]}, 1'b1);
      chk(eraseCommit, {1'b1, fsec_kind_type'(k), BASES[k]});
      chk({flagStatus, welOut}, {8'h80, 1'b0});
    end
    @(posedge clk);
    protoMode <= MODE_EXT;
    addr4Byte <= 1'b0;
    sectorLock[10'h23] <= 1'b1;
    for (k = 0; k < 2; k++)
    begin
      frame(OP_WREN, 0, 0, 1, 0);
      frame(k ? OP_DIE_ERASE : OP_SUB_ERASE, 32'h235000, 24, 1, 0);
      chk({flagStatus, welOut, busyOut}, {8'ha2, 2'b10});
      frame(OP_CLR_FLAGS, 0, 0, 1, 0);
      chk(flagStatus, 8'h80);
    end
    @(posedge clk);
    sectorLock <= '0;
    arrayTimeout <= 1'b1;
    frame(OP_SUB_ERASE, 32'h1000, 24, 1, 0);
    wt(2, SSE + 100);
    // A commit would stand in this very cycle
    chk({flagStatus, welOut, eraseCommit.go}, {8'ha0, 2'b00});
    arrayTimeout <= 1'b0;
    frame(OP_CLR_FLAGS, 0, 0, 1, 0);
    frame(OP_WREN, 0, 0, 1, 0);
    frame(OP_SEC_ERASE, 32'h41234, 24, 1, 0);
    frame(OP_SUSPEND, 0, 0, 1, 0);
    t0 = cyc;
    chk({flagStatus, busyOut}, {8'h40, 1'b1});
    wt(2, 2000);
    chk((cyc - t0) inside {[1490 : 1502]}, 1'b1);
    frame(OP_SUSPEND, 0, 0, 1, 0);
    chk({flagStatus, busyOut}, {8'hc0, 1'b0});
    @(posedge clk);
    progStart <= 1'b1;
    @(posedge clk);
    progStart <= 1'b0;
    frame(OP_SUSPEND, 0, 0, 1, 0);
    chk({flagStatus, busyOut}, {8'h44, 1'b1});
    wt(2, 1000);
    chk(flagStatus, 8'hc4);
    frame(OP_RESUME, 0, 0, 1, 0);
    chk(flagStatus, 8'h40);
    wt(1, 3100);
    @(posedge clk);
    #1;
    chk(flagStatus, 8'hc0);
    frame(OP_RESUME, 0, 0, 1, 0);
    chk({flagStatus, busyOut}, {8'h00, 1'b1});
    wt(0, SE);
    chk(eraseCommit, {1'b1, KIND_SEC, 32'h40000});
    frame(OP_WREN, 0, 0, 1, 0);
    frame(OP_SUB_ERASE, 32'h7fff, 24, 1, 0);
    repeat (SSE - 1000) @(posedge clk);
    frame(OP_SUSPEND, 0, 0, 1, 0);
    chk(flagStatus.eraseSusp, 1'b1);
    wt(0, 1200);
    chk({eraseCommit.base, flagStatus}, {32'h7000, 8'h80});
    give_verdict();
  end
endmodule : fsec_erase_ctrl_tb
`default_nettype wire
